// ### rtl/shifter.sv
// Purpose: eight-stage parallel-load shifter with serial bit stream out
// Assumes: all pin inputs asynchronous to clk_sys; pins change slower
//          than the 40 MHz sample rate
// Notes:   shifted-out bits queue in a fifo; when it is full a shift
//          edge is dropped and overrun is raised until reset
//
// Notes on behaviour
// R1: eight stages shift first toward last
// R2: parallel inputs act only while load low
// R3: last stage drives true and complement outputs
// R4: clock is NOR of two clock inputs
// R5: one clock low lets other clock shift
// R6: far side raises inhibit only while clock high
// R7: parallel inputs ignored while shift high
// R8: load low follows parallel inputs, overrides all
// R9: rising edge loads serial in, shifts rest
// R10: no edge or inhibit high holds everything
`timescale 1ns/1ps

module shift_fifo
    import shifter_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 count;
        logic                        valid;  // flop copy of count != 0
        logic [WIDTH-1:0]            head;   // flop copy of head word
    } fifo_state_t;

    fifo_state_t s_q;
    fifo_state_t s_d;
    logic        push;
    logic        pop;

    // wrap explicitly so non-power-of-two depths work too
    function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign inReady  = (s_q.count != FULL_CNT);
    assign outValid = s_q.valid;
    assign outData  = s_q.head;

    // one push and one pop may happen in the same cycle
    always_comb begin
        s_d  = s_q;
        push = inValid && inReady;
        pop  = outValid && outReady;
        if (push) begin
            s_d.mem[s_q.wr] = inData;
            s_d.wr          = nextPtr(s_q.wr);
        end
        if (pop) begin
            s_d.rd = nextPtr(s_q.rd);
        end
        if (push && !pop) begin
            s_d.count = s_q.count + 1'b1;
        end else if (pop && !push) begin
            s_d.count = s_q.count - 1'b1;
        end
        // head and valid are registered so the outputs leave from flops;
        // computed from next state, so no extra cycle of latency
        s_d.valid = (s_d.count != '0);
        s_d.head  = s_d.mem[s_d.rd];
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // shift_fifo

module shifter
    import shifter_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    input  wire logic                   shiftNotLoad,
    input  wire logic                   clockIn,
    input  wire logic                   clockBlockInput,
    input  wire logic                   serialIn,
    input  wire logic [STAGE_COUNT-1:0] parallelIn,
    output logic                        lastTrue,
    output logic                        lastComp,
    output logic                        overrun,
    output logic                        outValid,
    input  wire logic                   outReady,
    output logic      [FIFO_WIDTH-1:0]  outData
);
    typedef struct packed {
        logic [PIN_W-1:0]       pinMeta;  // first sync stage only
        logic [PIN_W-1:0]       pinSync;
        logic                   effPrev;
        logic [STAGE_COUNT-1:0] stages;   // bit 0 first, top bit last
        logic                   lastTrue;
        logic                   lastComp;
        logic                   overrun;
    } shifter_state_t;

    shifter_state_t s_q;
    shifter_state_t s_d;
    logic           effClk;
    logic           shiftEdge;
    logic           fifoReady;
    logic           pushBit;

    // gated clock: high only while both inputs are low
    function automatic logic clockNor(input logic a, input logic b);
        return !(a || b);
    endfunction

    assign effClk = clockNor(s_q.pinSync[POS_CLK],
                             s_q.pinSync[POS_INH]); // R4
    assign shiftEdge = effClk && !s_q.effPrev && s_q.pinSync[POS_SHL]; // R5

    // stage logic; an edge lost to a full fifo keeps the chain intact
    always_comb begin
        s_d         = s_q;
        pushBit     = 1'b0;
        s_d.pinMeta = {shiftNotLoad, clockIn, clockBlockInput, serialIn,
                       parallelIn};
        s_d.pinSync = s_q.pinMeta;
        s_d.effPrev = effClk;
        if (!s_q.pinSync[POS_SHL]) begin
            // load overrides clocks and serial input
            s_d.stages = s_q.pinSync[POS_PAR +: STAGE_COUNT]; // R2 R8
        end else if (shiftEdge) begin // R7
            if (fifoReady) begin
                pushBit    = 1'b1;
                s_d.stages = {s_q.stages[STAGE_COUNT-2:0],
                              s_q.pinSync[POS_SER]}; // R1 R9
            end else begin
                s_d.overrun = 1'b1;
            end
        end
        // otherwise stages hold: no edge or inhibit high  R10
        s_d.lastTrue = s_d.stages[STAGE_COUNT-1]; // R3
        s_d.lastComp = !s_d.stages[STAGE_COUNT-1]; // R3
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s_q          <= '0;
            s_q.pinMeta  <= PIN_RST;
            s_q.pinSync  <= PIN_RST;
            s_q.stages   <= STAGE_RST;
            s_q.lastComp <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign lastTrue = s_q.lastTrue;
    assign lastComp = s_q.lastComp;
    assign overrun  = s_q.overrun;

    // the bit pushed out is the old last stage
    shift_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_shift_fifo (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .inValid  (pushBit),
        .inData   (s_q.stages[STAGE_COUNT-1]),
        .inReady  (fifoReady),
        .outValid (outValid),
        .outReady (outReady),
        .outData  (outData)
    );

    property p_shift;
        @(posedge clk_sys) disable iff (!resetn)
        (shiftEdge && fifoReady) |=> s_q.stages ==
            {$past(s_q.stages[STAGE_COUNT-2:0]), $past(s_q.pinSync[POS_SER])};
    endproperty
    a_shift: assert property (p_shift) // R1
        else $error("stages did not shift on edge");

    property p_load;
        @(posedge clk_sys) disable iff (!resetn)
        !s_q.pinSync[POS_SHL] |=> s_q.stages ==
            $past(s_q.pinSync[POS_PAR +: STAGE_COUNT]);
    endproperty
    a_load: assert property (p_load) // R8
        else $error("load did not copy parallel inputs");

    property p_ignore_par;
        @(posedge clk_sys) disable iff (!resetn)
        (s_q.pinSync[POS_SHL] && !shiftEdge) |=> $stable(s_q.stages);
    endproperty
    a_ignore_par: assert property (p_ignore_par) // R7
        else $error("stages changed without load or edge");

    property p_comp;
        @(posedge clk_sys) disable iff (!resetn)
        ##1 (lastComp == !lastTrue) && (lastTrue == s_q.stages[7]);
    endproperty
    a_comp: assert property (p_comp) // R3
        else $error("outputs do not match last stage");

    property p_inhibit;
        @(posedge clk_sys) disable iff (!resetn)
        (s_q.pinSync[POS_INH] && s_q.pinSync[POS_SHL]) |=>
            $stable(s_q.stages);
    endproperty
    a_inhibit: assert property (p_inhibit) // R4
        else $error("shift while inhibit high");

    property p_edge;
        @(posedge clk_sys) disable iff (!resetn)
        (s_q.pinSync[POS_SHL] && !s_q.pinSync[POS_INH] &&
         !s_q.pinSync[POS_CLK] && $past(s_q.pinSync[POS_CLK]) &&
         !$past(s_q.pinSync[POS_INH])) |-> shiftEdge;
    endproperty
    a_edge: assert property (p_edge) // R5
        else $error("clock transition not taken as shift");

    property p_serial;
        @(posedge clk_sys) disable iff (!resetn)
        (shiftEdge && fifoReady) |=> s_q.stages[0] ==
            $past(s_q.pinSync[POS_SER]);
    endproperty
    a_serial: assert property (p_serial) // R9
        else $error("first stage missed serial input");

    property p_hold;
        @(posedge clk_sys) disable iff (!resetn)
        (s_q.pinSync[POS_SHL] && !shiftEdge) [*2] |=>
            $stable(lastTrue) && $stable(lastComp);
    endproperty
    a_hold: assert property (p_hold) // R10
        else $error("outputs moved without edge");

    property p_par_only_load;
        @(posedge clk_sys) disable iff (!resetn)
        ($changed(s_q.stages) && !$past(shiftEdge)) |->
            !$past(s_q.pinSync[POS_SHL]);
    endproperty
    a_par_only_load: assert property (p_par_only_load) // R2
        else $error("stage changed from parallel input while shifting");
endmodule // shifter

// ### rtl/shifter_pkg.sv
// Purpose: shared constants for the parallel-in serial-out shifter
// Assumes: one 40 MHz system clock, synchronous active-low reset
// Notes:   pin vector layout is {shiftNotLoad, clockIn, clockBlockInput,
//          serialIn, parallelIn}
package shifter_pkg;
    localparam int STAGE_COUNT = 8;             // storage stages
    localparam int PIN_W       = STAGE_COUNT + 4;
    // field positions inside the sampled pin vector
    localparam int POS_PAR     = 0;
    localparam int POS_SER     = STAGE_COUNT;
    localparam int POS_INH     = STAGE_COUNT + 1;
    localparam int POS_CLK     = STAGE_COUNT + 2;
    localparam int POS_SHL     = STAGE_COUNT + 3;
    // values after reset: clock input high, so no edge is seen at release
    localparam logic [PIN_W-1:0] PIN_RST = 12'hC00;
    localparam logic [STAGE_COUNT-1:0] STAGE_RST = 8'h00;
    // output fifo geometry
    localparam int FIFO_WIDTH  = 1;
    localparam int FIFO_DEPTH  = 32;
endpackage

// ### testbench/pin_driver.sv
// Purpose: controlling logic model that drives the shifter pins
// Assumes: each pin setting is held 5 clk_sys cycles
// Notes:   pins change just after a rising edge, by non-blocking writes
`timescale 1ns/1ps
module pin_driver (
    input  wire logic       clk_sys,
    output logic            shiftNotLoad,
    output logic            clockIn,
    output logic            clockBlockInput,
    output logic            serialIn,
    output logic      [7:0] parallelIn
);
    // idle with clock high, so reset release sees no edge
    initial begin
        shiftNotLoad = 1'b1;
        clockIn = 1'b1;
        clockBlockInput = 1'b0;
        serialIn = 1'b0;
        parallelIn = 8'h00;
    end
    // long hold: sync depth plus state flop, so every change lands
    task automatic pins(input logic sl, input logic ck, input logic inh,
                        input logic serial_in, input logic [7:0] par);
        @(posedge clk_sys);
        shiftNotLoad <= sl;
        clockIn <= ck;
        clockBlockInput <= inh;
        serialIn <= serial_in;
        parallelIn <= par;
        repeat (4) @(posedge clk_sys);
    endtask
    // clock low then high with the inhibit low throughout
    task automatic pulse(input logic serial_in, input logic [7:0] par);
        pins(1'b1, 1'b0, 1'b0, serial_in, par);
        pins(1'b1, 1'b1, 1'b0, serial_in, par);
    endtask
endmodule // pin_driver

// ### testbench/shifter_test.sv
// Purpose: self-checking bench for the shifter and its bit fifo
// Assumes: 40 MHz clk_sys, 3-cycle pin-to-output latency
// Notes:   stg mirrors the stages; q holds bits expected from the fifo
`timescale 1ns/1ps
module shifter_test;
    import shifter_pkg::*;
    logic       clk_sys = 1'b0;
    logic       resetn = 1'b0;
    logic       outReady = 1'b0;
    logic       shiftNotLoad, clockIn, clockBlockInput, serialIn;
    logic [7:0] parallelIn;
    logic       lastTrue, lastComp, overrun, outValid;
    logic [0:0] outData;
    logic [7:0] stg;
    logic       q[$];
    int         num_errors = 0;
    int         check_count = 0;

    always #12.5 clk_sys = ~clk_sys;

    pin_driver u_pin_driver (.clk_sys(clk_sys),
        .shiftNotLoad(shiftNotLoad), .clockIn(clockIn),
        .clockBlockInput(clockBlockInput), .serialIn(serialIn),
        .parallelIn(parallelIn));
    shifter u_shifter (.clk_sys(clk_sys), .resetn(resetn),
        .shiftNotLoad(shiftNotLoad), .clockIn(clockIn),
        .clockBlockInput(clockBlockInput), .serialIn(serialIn),
        .parallelIn(parallelIn), .lastTrue(lastTrue),
        .lastComp(lastComp), .overrun(overrun), .outValid(outValid),
        .outReady(outReady), .outData(outData));

    task automatic complete_run();
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one-bit compare; every result of this block is a single bit
    task automatic chk(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] %s exp %b got %b", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic chk_last();
        @(negedge clk_sys);
        chk("lastTrue", stg[7], lastTrue);
        chk("lastComp", ~stg[7], lastComp);
    endtask
    // ok low: fifo is full, so the edge is refused and nothing moves
    task automatic do_shift(input logic serial_in, input logic ok);
        u_pin_driver.pulse(serial_in, ~stg);
        if (ok) begin
            q.push_back(stg[7]);
            stg = {stg[6:0], serial_in};
        end
        chk_last();
    endtask
    // pop one bit; bounded wait so a stuck fifo ends the run
    task automatic drain();
        int n = 0;
        while (outValid !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        chk("outValid", 1'b1, outValid);
        if (outValid !== 1'b1) complete_run();
        chk("outData", q.pop_front(), outData[0]);
        @(posedge clk_sys) outReady <= 1'b1;
        @(posedge clk_sys) outReady <= 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic drain_all();
        while (q.size() > 0) drain();
        chk("outValid", 1'b0, outValid);
    endtask
    // load overrides clock and serial pins while shiftNotLoad is low
    task automatic t_load(input logic [7:0] v);
        u_pin_driver.pins(1'b0, 1'b1, 1'b0, 1'b1, ~v);
        u_pin_driver.pins(1'b0, 1'b0, 1'b0, 1'b0, v);
        u_pin_driver.pins(1'b1, 1'b1, 1'b0, 1'b1, v);
        stg = v;
        chk_last();
    endtask
    task automatic t_shift8();
        t_load(8'hA5);
        for (int i = 0; i < 8; i++) do_shift(i[0], 1'b1);
        drain_all();
    endtask
    // inhibit blocks clockIn; then clockIn low lets inhibit clock
    task automatic t_inhibit();
        u_pin_driver.pins(1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
        u_pin_driver.pins(1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
        u_pin_driver.pins(1'b1, 1'b1, 1'b1, 1'b1, 8'h00);
        chk_last();
        chk("outValid", 1'b0, outValid);
        u_pin_driver.pins(1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
        u_pin_driver.pins(1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
        q.push_back(stg[7]);
        stg = {stg[6:0], 1'b1};
        chk_last();
        u_pin_driver.pins(1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
        drain_all();
    endtask
    // fill all 32 fifo places, then one more shift must be refused
    task automatic t_overrun();
        t_load(8'h5A);
        for (int i = 0; i < FIFO_DEPTH; i++) do_shift(i[1], 1'b1);
        chk("overrun", 1'b0, overrun);
        do_shift(1'b1, 1'b0);
        chk("overrun", 1'b1, overrun);
        drain_all();
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        @(negedge clk_sys);
        chk("lastComp", 1'b1, lastComp);
        chk("outValid", 1'b0, outValid);
        t_shift8();
        t_inhibit();
        t_overrun();
        complete_run();
    end
endmodule // shifter_test
